// File: src/hbs_pkg.sv
package hbs_pkg;

  // bit positions in configuration words
  localparam int unsigned SUBMODE_AUTO_BIT = 2;
  localparam int unsigned DOUT_BRAKE_BIT = 0;

  // pwm limits
  localparam logic [11:0] PWM_FREQ_MAX_HZ = 12'd2000;
  localparam logic [6:0] PWM_DUTY_MIN = 7'd2;
  localparam logic [6:0] PWM_DUTY_MAX = 7'd100;

  // timing
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CLK_PER_MS = CLK_FREQ_HZ / 1000;

  // reset values
  localparam logic [11:0] PWM_FREQ_RST = 12'h3E8;
  localparam logic [6:0] PWM_DUTY_RST = 7'h64;

  typedef struct packed {
    logic [15:0] rel_dly1_ms;
    logic [15:0] rel_dly2_ms;
    logic [15:0] eng_dly1_ms;
    logic [15:0] eng_dly2_ms;
  } hbs_timing_s;

  typedef struct packed {
    logic [11:0] freq_hz;
    logic [6:0] duty_pct;
  } hbs_pwm_s;

  // gray codes along the release then engage path, except the ST_ENG_HOLD to ST_OFF return
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_REL_WAIT = 3'b001,
    ST_REL_HOLD = 3'b011,
    ST_RUN = 3'b010,
    ST_STOPPING = 3'b110,
    ST_ENG_WAIT = 3'b111,
    ST_ENG_HOLD = 3'b101
  } hbs_state_e;

endpackage

// File: src/hbs_pwm.sv
`timescale 1ns/1ps
module hbs_pwm
  import hbs_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_FREQ_HZ
)
(
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire hbs_pwm_s cfg, // range-checked frequency and duty
  output logic pwm_out // pwm waveform
);

  logic [31:0] period_ff, nxt_period;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [31:0] high_len;
  logic out_ff, nxt_out;

  // divide is slow but cfg changes rarely; period recomputed every cycle
  always_comb
  begin
    nxt_period = (cfg.freq_hz == 12'h000) ? 32'(CLK_HZ / 1)
                 : 32'(CLK_HZ / 32'(cfg.freq_hz));
    high_len = 32'((64'(period_ff) * 64'(cfg.duty_pct)) / 64'd100);
    nxt_cnt = (cnt_ff + 32'd1 >= period_ff) ? 32'd0 : cnt_ff + 32'd1;
    nxt_out = (cfg.duty_pct >= PWM_DUTY_MAX) ? 1'b1
              : (cnt_ff < high_len);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      period_ff <= 32'd0;
      cnt_ff <= 32'd0;
      out_ff <= 1'b0;
    end
    else
    begin
      period_ff <= nxt_period;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign pwm_out = out_ff;

endmodule

// File: src/hbs_brake.sv
`timescale 1ns/1ps
module hbs_brake
  import hbs_pkg::*;
#(
  parameter int unsigned TICKS_PER_MS = CLK_PER_MS
)
(
  input wire logic CLOCK, // 100 MHz system clock
  input wire logic RST, // synchronous reset, active high
  input wire logic [15:0] SUBMODE, // drive submode setting
  input wire logic [15:0] DOUT_WORD, // special-function output bits
  input wire logic OVR_MASK, // manual override enable for brake
  input wire logic OVR_VALUE, // manual override brake value
  input wire logic RUN_REQ, // power state machine wants drive-running
  input wire logic STANDSTILL, // motor reports standstill
  input wire hbs_timing_s TIMING, // four wait intervals in ms
  input wire logic CFG_WE, // write strobe for pwm settings
  input wire hbs_pwm_s CFG_WDATA, // requested pwm settings
  output logic CFG_ERR, // last pwm write refused
  output hbs_pwm_s PWM_CFG, // active pwm settings
  output logic BRAKE_OUT, // brake on (energised = released)
  output logic CURRENT_EN, // motor current enable
  output logic MOTION_OK, // motion commands accepted
  output logic STOP_REQ // request to bring motor to standstill
);

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  hbs_pwm_s pwm_cfg_ff, nxt_pwm_cfg;
  logic cfg_err_ff, nxt_cfg_err;
  logic cfg_ok;

  always_comb
  begin
    cfg_ok = (CFG_WDATA.freq_hz <= PWM_FREQ_MAX_HZ)
             && (CFG_WDATA.duty_pct >= PWM_DUTY_MIN)
             && (CFG_WDATA.duty_pct <= PWM_DUTY_MAX);
    nxt_pwm_cfg = pwm_cfg_ff;
    nxt_cfg_err = cfg_err_ff;
    if (CFG_WE)
    begin
      nxt_cfg_err = !cfg_ok;
      if (cfg_ok)
        nxt_pwm_cfg = CFG_WDATA;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      pwm_cfg_ff <= '{freq_hz: PWM_FREQ_RST, duty_pct: PWM_DUTY_RST};
      cfg_err_ff <= 1'b0;
    end
    else
    begin
      pwm_cfg_ff <= nxt_pwm_cfg;
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  hbs_state_e state_ff, nxt_state;
  logic [15:0] ms_ff, nxt_ms;
  logic [31:0] tick_ff, nxt_tick;
  logic expired;

  function automatic logic [15:0] load_dly(input logic [15:0] ms);
    load_dly = ms;
  endfunction

  assign expired = (ms_ff == 16'h0000);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ms = ms_ff;
    nxt_tick = tick_ff;
    // ms prescaler; one ms decrement per TICKS_PER_MS cycles
    if (!expired)
    begin
      if (tick_ff + 32'd1 >= 32'(TICKS_PER_MS))
      begin
        nxt_tick = 32'd0;
        nxt_ms = ms_ff - 16'h0001;
      end
      else
        nxt_tick = tick_ff + 32'd1;
    end
    unique case (state_ff)
      ST_OFF:
        if (RUN_REQ)
        begin
          nxt_state = ST_REL_WAIT;
          nxt_ms = load_dly(TIMING.rel_dly1_ms);
          nxt_tick = 32'd0;
        end
      ST_REL_WAIT:
        if (!RUN_REQ)
        begin
          nxt_state = ST_ENG_HOLD;
          nxt_ms = load_dly(TIMING.eng_dly2_ms);
          nxt_tick = 32'd0;
        end
        else if (expired)
        begin
          nxt_state = ST_REL_HOLD;
          nxt_ms = load_dly(TIMING.rel_dly2_ms);
          nxt_tick = 32'd0;
        end
      ST_REL_HOLD:
        if (!RUN_REQ)
          nxt_state = ST_STOPPING;
        else if (expired)
          nxt_state = ST_RUN;
      ST_RUN:
        if (!RUN_REQ)
          nxt_state = ST_STOPPING;
      ST_STOPPING:
        if (STANDSTILL)
        begin
          nxt_state = ST_ENG_WAIT;
          nxt_ms = load_dly(TIMING.eng_dly1_ms);
          nxt_tick = 32'd0;
        end
      ST_ENG_WAIT:
        if (expired)
        begin
          nxt_state = ST_ENG_HOLD;
          nxt_ms = load_dly(TIMING.eng_dly2_ms);
          nxt_tick = 32'd0;
        end
      ST_ENG_HOLD:
        if (expired)
          nxt_state = ST_OFF;
      default:
        nxt_state = ST_OFF;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state_ff <= ST_OFF;
      ms_ff <= 16'h0000;
      tick_ff <= 32'd0;
    end
    else
    begin
      state_ff <= nxt_state;
      ms_ff <= nxt_ms;
      tick_ff <= nxt_tick;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic pwm_wave;
  logic auto_rel, brake_cmd;
  logic brake_ff, nxt_brake;
  logic cur_ff, nxt_cur, mot_ff, nxt_mot, stop_ff, nxt_stop;

  hbs_pwm #(.CLK_HZ(CLK_FREQ_HZ)) u_pwm (
    .clock(CLOCK),
    .rst(RST),
    .cfg(pwm_cfg_ff),
    .pwm_out(pwm_wave)
  );

  always_comb
  begin
    // released from end of first release wait until end of first engage wait
    auto_rel = (state_ff == ST_REL_HOLD) || (state_ff == ST_RUN)
               || (state_ff == ST_STOPPING) || (state_ff == ST_ENG_WAIT);
    brake_cmd = SUBMODE[SUBMODE_AUTO_BIT] ? auto_rel
                : DOUT_WORD[DOUT_BRAKE_BIT];
    if (OVR_MASK)
      brake_cmd = OVR_VALUE;
    nxt_brake = brake_cmd && pwm_wave;
    nxt_cur = (state_ff != ST_OFF);
    nxt_mot = (state_ff == ST_RUN);
    nxt_stop = (state_ff == ST_STOPPING);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      brake_ff <= 1'b0;
      cur_ff <= 1'b0;
      mot_ff <= 1'b0;
      stop_ff <= 1'b0;
    end
    else
    begin
      brake_ff <= nxt_brake;
      cur_ff <= nxt_cur;
      mot_ff <= nxt_mot;
      stop_ff <= nxt_stop;
    end
  end

  assign BRAKE_OUT = brake_ff;
  assign CURRENT_EN = cur_ff;
  assign MOTION_OK = mot_ff;
  assign STOP_REQ = stop_ff;
  assign CFG_ERR = cfg_err_ff;
  assign PWM_CFG = pwm_cfg_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_auto_engaged: assert property (@(posedge CLOCK) disable iff (RST)
    (SUBMODE[SUBMODE_AUTO_BIT] && !OVR_MASK && state_ff == ST_OFF)
    |=> !BRAKE_OUT)
    else $error("brake released outside running sequence");
  a_manual_bit: assert property (@(posedge CLOCK) disable iff (RST)
    (!SUBMODE[SUBMODE_AUTO_BIT] && !OVR_MASK && !DOUT_WORD[DOUT_BRAKE_BIT])
    |=> !BRAKE_OUT)
    else $error("manual brake bit ignored");
  a_release_order: assert property (@(posedge CLOCK) disable iff (RST)
    (state_ff == ST_OFF && RUN_REQ) |=> state_ff == ST_REL_WAIT
    ##1 CURRENT_EN)
    else $error("current not enabled first");
  a_motion_late: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(MOTION_OK) |-> $past(state_ff) == ST_RUN
    && $past(state_ff, 2) == ST_REL_HOLD && $past(expired, 2))
    else $error("motion accepted before delays");
  a_engage_order: assert property (@(posedge CLOCK) disable iff (RST)
    (state_ff == ST_ENG_HOLD) |=> CURRENT_EN)
    else $error("current off before engage delay");
  a_freq_refused: assert property (@(posedge CLOCK) disable iff (RST)
    (CFG_WE && CFG_WDATA.freq_hz > PWM_FREQ_MAX_HZ)
    |=> CFG_ERR && $stable(PWM_CFG))
    else $error("frequency above limit accepted");
  a_duty_range: assert property (@(posedge CLOCK) disable iff (RST)
    PWM_CFG.duty_pct >= PWM_DUTY_MIN && PWM_CFG.duty_pct <= PWM_DUTY_MAX)
    else $error("duty out of range");
  a_full_duty: assert property (@(posedge CLOCK) disable iff (RST)
    (pwm_cfg_ff.duty_pct == PWM_DUTY_MAX && OVR_MASK && OVR_VALUE)[*3]
    |-> BRAKE_OUT)
    else $error("full duty output pulses");
  a_override: assert property (@(posedge CLOCK) disable iff (RST)
    (OVR_MASK && !OVR_VALUE) |=> !BRAKE_OUT)
    else $error("override not honoured");
  a_wait_count: assert property (@(posedge CLOCK) disable iff (RST)
    (state_ff == ST_ENG_WAIT && !expired) |=> state_ff == ST_ENG_WAIT)
    else $error("step advanced before expiry");

endmodule

// File: dv/hbs_motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// motor and power stage stand-in
// ----------------------------------------
module hbs_motor_model
#(
  parameter int unsigned STOP_CYC = 15
)
(
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic stop_req, // stop request from sequencer
  output logic standstill // rotor at rest
);
  int unsigned cnt_ff;
  // the rotor needs time to coast down, so a slow stop is the normal case
  always_ff @(posedge clock)
  begin
    if (rst || !stop_req)
      cnt_ff <= 0;
    else if (cnt_ff < STOP_CYC)
      cnt_ff <= cnt_ff + 1;
  end
  assign standstill = stop_req && (cnt_ff >= STOP_CYC);
endmodule

// File: dv/holding_brake_sequencer_pwm_test.sv
`timescale 1ns/1ps
module holding_brake_sequencer_pwm_test;
  import hbs_pkg::*;
  localparam int TK = 10;
  localparam int STOP = 15;
  logic clock, rst, cfg_we, ovr_mask, ovr_value, run_req, standstill;
  logic cfg_err, brake_out, current_en, motion_ok, stop_req;
  logic [15:0] submode, dout_word;
  hbs_timing_s timing;
  hbs_pwm_s cfg_wdata, pwm_cfg, cur_cfg;
  int mismatches, total_checks, cyc_cnt, n, hi;
  logic [31:0] rng_ff;
  logic opened;

  hbs_brake #(.TICKS_PER_MS(TK)) i_dut (.CLOCK(clock), .RST(rst),
    .SUBMODE(submode), .DOUT_WORD(dout_word), .OVR_MASK(ovr_mask),
    .OVR_VALUE(ovr_value), .RUN_REQ(run_req), .STANDSTILL(standstill),
    .TIMING(timing), .CFG_WE(cfg_we), .CFG_WDATA(cfg_wdata),
    .CFG_ERR(cfg_err), .PWM_CFG(pwm_cfg), .BRAKE_OUT(brake_out),
    .CURRENT_EN(current_en), .MOTION_OK(motion_ok), .STOP_REQ(stop_req));
  hbs_motor_model #(.STOP_CYC(STOP)) i_motor (.clock(clock), .rst(rst),
    .stop_req(stop_req), .standstill(standstill));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] xs();
    rng_ff = rng_ff ^ (rng_ff << 13);
    rng_ff = rng_ff ^ (rng_ff >> 17);
    rng_ff = rng_ff ^ (rng_ff << 5);
    return rng_ff;
  endfunction
  function logic sel(int k);
    case (k)
      0: return brake_out;
      1: return current_en;
      2: return motion_ok;
      default: return stop_req;
    endcase
  endfunction
  task results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [18:0] seen, input logic [18:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task near(input int v, input int e, input int tol);
    check(19'((v + tol >= e) && (v <= e + tol)), 19'h00001);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // bounded so a stuck sequencer shows as a mismatch, not a hang
  task wait_lvl(input int k, input logic lvl, output int cnt);
    cnt = 0;
    while (sel(k) !== lvl && cnt < 2000)
    begin
      cyc(1);
      cnt++;
    end
  endtask
  task wr_cfg(input logic [11:0] f, input logic [6:0] d);
    logic bad;
    bad = f > PWM_FREQ_MAX_HZ || d < PWM_DUTY_MIN || d > PWM_DUTY_MAX;
    if (!bad)
      cur_cfg = {f, d};
    cfg_wdata = {f, d};
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    check(19'(cfg_err), 19'(bad));
    check(pwm_cfg, cur_cfg);
    // an idle edge keeps back-to-back writes from retoggling the strobe
    cyc(1);
  endtask
  task run_seq();
    timing = {16'(xs() % 8), 16'(xs() % 8), 16'(xs() % 8), 16'(xs() % 8)};
    run_req = 1'b1;
    wait_lvl(1, 1'b1, n);
    near(n, 2, 2);
    check(19'({brake_out, motion_ok}), 19'h00000);
    wait_lvl(0, 1'b1, n);
    near(n, timing.rel_dly1_ms * TK, 3);
    check(19'(motion_ok), 19'h00000);
    wait_lvl(2, 1'b1, n);
    near(n, timing.rel_dly2_ms * TK, 3);
    run_req = 1'b0;
    wait_lvl(2, 1'b0, n);
    near(n, 2, 2);
    check(19'({stop_req, brake_out, current_en}), 19'h00007);
    wait_lvl(0, 1'b0, n);
    near(n, STOP + timing.eng_dly1_ms * TK, 4);
    check(19'(current_en), 19'h00001);
    wait_lvl(1, 1'b0, n);
    near(n, timing.eng_dly2_ms * TK, 3);
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc_cnt++;
    if (cyc_cnt >= 90000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    rng_ff = 32'hBEA05B15;
    {rst, cfg_we, ovr_mask, ovr_value, run_req} = 5'h10;
    {submode, dout_word, timing, cfg_wdata} = '0;
    cur_cfg = {PWM_FREQ_RST, PWM_DUTY_RST};
    cyc(2);
    rst = 1'b0;
    check(pwm_cfg, cur_cfg);
    check(19'({cfg_err, brake_out, current_en, motion_ok}), 19'h00000);
    wr_cfg(12'h7D1, 7'h32);
    wr_cfg(12'h7D0, 7'h02);
    wr_cfg(12'h3E8, 7'h01);
    wr_cfg(12'h3E8, 7'h65);
    repeat (20) wr_cfg(12'(xs()), 7'(xs()));
    wr_cfg(12'h7D0, 7'h19);
    dout_word = 16'h0001;
    cyc(3);
    hi = 0;
    repeat (CLK_FREQ_HZ / 2000)
    begin
      cyc(1);
      hi += int'(brake_out === 1'b1);
    end
    near(hi, (CLK_FREQ_HZ / 2000) * 25 / 100, 2);
    dout_word = 16'h0000;
    cyc(3);
    check(19'(brake_out), 19'h00000);
    wr_cfg(12'(xs() % 2001), 7'h64);
    dout_word = 16'h0001;
    cyc(3);
    hi = 0;
    repeat (100)
    begin
      cyc(1);
      hi += int'(brake_out === 1'b1);
    end
    near(hi, 100, 0);
    {ovr_mask, ovr_value} = 2'h2;
    cyc(3);
    check(19'(brake_out), 19'h00000);
    {ovr_mask, ovr_value, dout_word} = {2'h3, 16'h0000};
    cyc(3);
    check(19'(brake_out), 19'h00001);
    {ovr_mask, ovr_value, dout_word} = {2'h0, 16'h0001};
    submode = 16'h0001 << SUBMODE_AUTO_BIT;
    cyc(3);
    check(19'(brake_out), 19'h00000);
    repeat (3) run_seq();
    // drop the run request before the release wait ends
    timing.rel_dly1_ms = 16'h0014;
    run_req = 1'b1;
    opened = 1'b0;
    repeat (340)
    begin
      cyc(1);
      run_req = run_req && !current_en;
      opened = opened | brake_out;
    end
    check(19'({opened, current_en}), 19'h00000);
    results();
  end
endmodule
